/* hdl/cig_consts.vh */
// Constants for the processor I/O cycle glue logic
// Overview of operation
// - Assert I/O wait on I/O request with read or write until chain completes.
// - Four-stage I/O timing chain held cleared until an I/O request appears.
// - Registered direction line: low for I/O write, high for I/O read.
// - Peripheral enable during refresh cycles or from timing chain during I/O.
// - Disk write strobe from first chain stage, qualified by last stage, on write.
// - Disk read strobe from first chain stage with processor read, unqualified.
// - Counter-timer read and write strobes are the disk read and write strobes.
// - Pushbutton sets stage one, sync moves to stage two, refresh to stage three.
// - Stage two clears stage one; next sync clears stage three, ending reset.
// - Pushbutton reset stays short, bounded by sync sequencing, preserving DRAM.
// - Pushbutton reset also raises an interrupt request to the processor.
// - Power-on detector asserts reset asynchronously; release follows two clocks after it drops.
// - System reset fans out to processor and all peripheral resets.
// - I/O request with opcode fetch forms acknowledge, driving data bit 0 low.
// - Serial controller supplies vector; otherwise pulled-up lines give FE.
// - Video RAM stall while DMA or display read of video RAM is active.
// - Bus request and non-maskable interrupt held inactive high.
// - One-of-eight decoder gives at most one active-low chip select.
// - Decode only when stretched select active and address bit 7 low.
// - Address bits 0 and 1 choose the system peripheral's internal function.
// - I/O chip select starts on request with read or write, then latched.
// - Port addresses 00 to 03 select the system parallel interface peripheral.
`ifndef CIG_CONSTS_VH
`define CIG_CONSTS_VH
`define CIG_CHAIN_LEN     4
`define CIG_TICK_DIV      50
`define CIG_TICK_W        6
`define CIG_VECTOR_FIXED  8'hFE
`define CIG_SYS_PORT_LO   8'h00
`define CIG_SYS_PORT_HI   8'h03
`define CIG_ADDR_EN_BIT   7
`endif

/* hdl/cig_glue.v */
// Processor I/O cycle glue: wait stretch, strobes, reset sequencing, I/O decode
`include "cig_consts.vh"
module cig_glue #(
  parameter TICK_DIV = `CIG_TICK_DIV
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Processor bus, active-low controls
  input  wire [7:0] cpu_addr,
  input  wire       io_request_n,
  input  wire       cpu_rd_n,
  input  wire       cpu_wr_n,
  input  wire       opcode_fetch_cycle_n,
  input  wire       refresh_cycle_flag_n,
  // Sequencing events and sources
  input  wire       hsync,
  input  wire       pushbutton,
  input  wire       power_on_n,
  input  wire       dma_active,
  input  wire       video_read_active,
  // Processor control outputs
  output wire       io_stretch_wait_n,
  output wire       video_ram_stall_n,
  output wire       cpu_wait_n,
  output wire       bus_request_in_n,
  output wire       nmi_n,
  output wire       pb_irq_n,
  output wire       sys_reset_n,
  // Interrupt acknowledge data bit 0
  output wire       ack_d0_out,
  output wire       ack_d0_oe,
  // Peripheral strobes
  output reg        io_direction_line,
  output wire       periph_enable,
  output wire       disk_read_strobe_n,
  output wire       disk_write_strobe_n,
  output wire       ctc_read_strobe_n,
  output wire       ctc_write_strobe_n,
  // Chip selects
  output wire       io_cycle_select_n,
  output wire [7:0] dev_select_n,
  output wire       system_port_select_n
);

  reg [`CIG_TICK_W-1:0] tick_cnt_r;
  reg [`CIG_CHAIN_LEN-1:0] chain_r;
  reg       io_cycle_select_latch_r;
  reg       pb_s1_r;
  reg       pb_s2_r;
  reg       pb_s3_r;
  reg       pb_irq_r;
  reg       pb_prev_r;
  reg       hs_prev_r;
  reg       rf_prev_r;
  reg       por_s1_r;
  reg       por_s2_r;
  wire      io_req;
  wire      tick;
  wire      hs_edge;
  wire      rf_edge;
  wire      pb_edge;
  wire      decode_en;

  // 4 MHz step derived from the 200 MHz system clock
  assign tick = (tick_cnt_r == TICK_DIV[`CIG_TICK_W-1:0] - 6'h01);
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_r <= 6'h00;
    else if (tick)
      tick_cnt_r <= 6'h00;
    else
      tick_cnt_r <= tick_cnt_r + 6'h01;
  end

  assign io_req = !io_request_n && (!cpu_rd_n || !cpu_wr_n);

  // Timing chain, cleared outside I/O requests so each cycle starts fresh
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      chain_r <= 4'h0;
    else if (!io_req)
      chain_r <= 4'h0;
    else if (tick)
      chain_r <= {chain_r[2:0], 1'b1};
  end

  // Wait until the last stage shows the access done
  assign io_stretch_wait_n = !(io_req && !chain_r[`CIG_CHAIN_LEN-1]);
  assign video_ram_stall_n = !(dma_active || video_read_active);
  assign cpu_wait_n = io_stretch_wait_n && video_ram_stall_n;
  assign bus_request_in_n = 1'b1;
  assign nmi_n = 1'b1;

  // Direction line registered from write indication
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      io_direction_line <= 1'b1;
    else if (io_req)
      io_direction_line <= cpu_wr_n;
  end

  assign periph_enable = !refresh_cycle_flag_n || (io_req && chain_r[`CIG_CHAIN_LEN-1]);
  // Write strobe waits for the chain end so data has settled on the bus
  assign disk_write_strobe_n = !(chain_r[0] && chain_r[`CIG_CHAIN_LEN-1] && !cpu_wr_n);
  assign disk_read_strobe_n = !(chain_r[0] && !cpu_rd_n);
  assign ctc_read_strobe_n = disk_read_strobe_n;
  assign ctc_write_strobe_n = disk_write_strobe_n;

  // Stretched I/O select: held until the request drops
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      io_cycle_select_latch_r <= 1'b0;
    else if (io_request_n)
      io_cycle_select_latch_r <= 1'b0;
    else if (io_req)
      io_cycle_select_latch_r <= 1'b1;
  end
  assign io_cycle_select_n = !(io_req || io_cycle_select_latch_r);

  // One-of-eight decode, gated by select and address bit 7
  assign decode_en = !io_cycle_select_n && !cpu_addr[`CIG_ADDR_EN_BIT];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_dec
      assign dev_select_n[gi] = !(decode_en && (cpu_addr[6:4] == gi));
    end
  endgenerate
  // Ports 00-03 land here; bits 0 and 1 pick the function inside the part
  assign system_port_select_n = dev_select_n[0];

  // Acknowledge forces bit 0 low; pull-ups give FE unless serial part drives
  assign ack_d0_oe = !io_request_n && !opcode_fetch_cycle_n;
  assign ack_d0_out = 1'b0;

  // Edge detection of sequencing events
  assign hs_edge = hsync && !hs_prev_r;
  assign rf_edge = !refresh_cycle_flag_n && rf_prev_r;
  assign pb_edge = pushbutton && !pb_prev_r;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hs_prev_r <= 1'b0;
      rf_prev_r <= 1'b1;
      pb_prev_r <= 1'b0;
    end
    else
    begin
      hs_prev_r <= hsync;
      rf_prev_r <= refresh_cycle_flag_n;
      pb_prev_r <= pushbutton;
    end
  end

  // Pushbutton sequencer: pulse spans one sync line, short enough for DRAM
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pb_s1_r <= 1'b0;
      pb_s2_r <= 1'b0;
      pb_s3_r <= 1'b0;
      pb_irq_r <= 1'b0;
    end
    else
    begin
      if (pb_s2_r)
        pb_s1_r <= 1'b0;
      else if (pb_edge)
        pb_s1_r <= 1'b1;
      if (hs_edge)
        pb_s2_r <= pb_s1_r;
      if (hs_edge && !pb_s1_r)
        pb_s3_r <= 1'b0;
      else if (rf_edge && pb_s2_r)
        pb_s3_r <= 1'b1;
      if (pb_s3_r)
        pb_irq_r <= 1'b1;
      else if (!opcode_fetch_cycle_n && !io_request_n)
        pb_irq_r <= 1'b0;
    end
  end
  assign pb_irq_n = !pb_irq_r;

  // Power-on detector synchronised for release; assert is immediate
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_s1_r <= 1'b0;
      por_s2_r <= 1'b0;
    end
    else
    begin
      por_s1_r <= !power_on_n;
      por_s2_r <= por_s1_r;
    end
  end
  assign sys_reset_n = !(pb_s3_r || !power_on_n || por_s2_r);

endmodule

/* verif/cig_assertions.sv */
// Port checker for the I/O cycle glue, bound into the design
module cig_chk #(parameter TICK_DIV = 50) (
  input wire       clk_sys, rst_n, io_request_n, cpu_rd_n, cpu_wr_n, opcode_fetch_cycle_n,
  input wire       refresh_cycle_flag_n, power_on_n, dma_active, video_read_active,
  input wire       io_stretch_wait_n, video_ram_stall_n, cpu_wait_n, bus_request_in_n, nmi_n,
  input wire       sys_reset_n, pb_irq_n, ack_d0_out, ack_d0_oe, io_direction_line, periph_enable,
  input wire       disk_read_strobe_n, disk_write_strobe_n, ctc_read_strobe_n, ctc_write_strobe_n,
  input wire       io_cycle_select_n, system_port_select_n,
  input wire [7:0] cpu_addr, dev_select_n
);
  localparam int MAXW = 4 * TICK_DIV + 2;
  // Qualified I/O request; an acknowledge cycle has neither strobe
  wire io_rq = !io_request_n && !(cpu_rd_n && cpu_wr_n);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wait_start_a: assert property ($fell(io_request_n) && io_rq |-> !io_stretch_wait_n && disk_read_strobe_n)
    else $error("wait missing or chain not clear at request");
  wait_end_a: assert property (io_rq && !io_stretch_wait_n |-> ##[1:MAXW] (io_stretch_wait_n || io_request_n))
    else $error("wait not released in time");
  dir_line_a: assert property (io_rq && $past(io_rq) |-> io_direction_line == cpu_wr_n)
    else $error("direction line wrong");
  enable_a: assert property (periph_enable == (!refresh_cycle_flag_n || io_rq && io_stretch_wait_n))
    else $error("peripheral enable wrong");
  wr_strobe_a: assert property (!disk_write_strobe_n |-> io_rq && !cpu_wr_n && io_stretch_wait_n)
    else $error("write strobe out of place");
  rd_strobe_a: assert property (io_rq && !cpu_rd_n && $rose(io_stretch_wait_n) |-> !disk_read_strobe_n)
    else $error("read strobe missing");
  timer_copy_a: assert property (ctc_read_strobe_n == disk_read_strobe_n && ctc_write_strobe_n == disk_write_strobe_n)
    else $error("timer strobes differ");
  int_ack_a: assert property (!io_request_n && !opcode_fetch_cycle_n |-> ack_d0_oe && !ack_d0_out)
    else $error("acknowledge bit not forced");
  decode_a: assert property (dev_select_n == (!io_cycle_select_n && !cpu_addr[7] ? ~(8'h01 << cpu_addr[6:4]) : 8'hFF)
    && system_port_select_n == dev_select_n[0])
    else $error("decode wrong");
  io_select_a: assert property (io_rq |-> !io_cycle_select_n)
    else $error("select missing");
  tie_high_a: assert property (bus_request_in_n && nmi_n)
    else $error("tied line low");
  stall_a: assert property (cpu_wait_n == (io_stretch_wait_n && video_ram_stall_n)
    && video_ram_stall_n == !(dma_active || video_read_active))
    else $error("stall wrong");
  power_rst_a: assert property (!power_on_n |-> !sys_reset_n)
    else $error("power-on reset missing");
  pb_irq_a: assert property ($fell(sys_reset_n) && power_on_n |=> !pb_irq_n)
    else $error("pushbutton irq missing");
  cover property ($rose(io_stretch_wait_n) && !cpu_wr_n);
  cover property (ack_d0_oe);
  cover property ($fell(sys_reset_n) && power_on_n);
endmodule
bind cig_glue cig_chk #(.TICK_DIV(TICK_DIV)) u_cig_chk (.*);

/* verif/cig_cpu.sv */
// Processor bus model: I/O and acknowledge cycles, idle refresh
module cig_cpu (
  input wire logic clk_sys, cpu_wait_n,
  output logic [7:0] cpu_addr,
  output logic io_request_n, cpu_rd_n, cpu_wr_n, opcode_fetch_cycle_n, refresh_cycle_flag_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Kind 0 read, 1 write, 2 acknowledge; held until wait is sampled high
  task automatic cycle(input logic [1:0] k, input logic [7:0] a);
    int n;
    @(posedge clk_sys) #1;
    cpu_addr = a;
    io_request_n = 0;
    {cpu_rd_n, cpu_wr_n, opcode_fetch_cycle_n} = {k != 0, k != 1, k != 2};
    n = 0;
    do @(posedge clk_sys); while (!cpu_wait_n && ++n < 999);
    #1 {io_request_n, cpu_rd_n, cpu_wr_n, opcode_fetch_cycle_n} = 4'hF;
    cpu_addr = ~a; // Released bus shows no stale value
  endtask
  // One refresh cycle every eight clocks, only between I/O cycles
  initial begin
    {io_request_n, cpu_rd_n, cpu_wr_n, opcode_fetch_cycle_n, refresh_cycle_flag_n} = 5'h1F;
    cpu_addr = 8'hFF;
    forever begin
      repeat (7) @(posedge clk_sys);
      #1 refresh_cycle_flag_n = !io_request_n;
      @(posedge clk_sys) #1 refresh_cycle_flag_n = 1;
    end
  end
endmodule

/* verif/cpu_io_cycle_glue_logic_bench.sv */
// Self-checking bench for the I/O cycle glue
module cpu_io_cycle_glue_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TD = 4;
  logic clk_sys = 0, rst_n = 0, hsync = 0, pushbutton = 0, power_on_n = 1, dma_active = 0, video_read_active = 0;
  logic [7:0] cpu_addr, dev_select_n, a;
  logic io_request_n, cpu_rd_n, cpu_wr_n, opcode_fetch_cycle_n, refresh_cycle_flag_n, w, prev_w = 1;
  logic io_stretch_wait_n, cpu_wait_n, pb_irq_n, sys_reset_n, io_direction_line, io_cycle_select_n;
  logic [8:0] q[$];
  int n_fail = 0, comparisons = 0, seed = 30518, i, len = 0;
  always #2.5 clk_sys = ~clk_sys;
  cig_cpu u_cig_cpu (.clk_sys, .cpu_wait_n, .cpu_addr, .io_request_n, .cpu_rd_n, .cpu_wr_n,
    .opcode_fetch_cycle_n, .refresh_cycle_flag_n);
  cig_glue #(.TICK_DIV(TD)) u_cig_glue (.clk_sys, .rst_n, .cpu_addr, .io_request_n, .cpu_rd_n, .cpu_wr_n,
    .opcode_fetch_cycle_n, .refresh_cycle_flag_n, .hsync, .pushbutton, .power_on_n, .dma_active,
    .video_read_active, .io_stretch_wait_n, .video_ram_stall_n(), .cpu_wait_n, .bus_request_in_n(), .nmi_n(),
    .pb_irq_n, .sys_reset_n, .ack_d0_out(), .ack_d0_oe(), .io_direction_line, .periph_enable(),
    .disk_read_strobe_n(), .disk_write_strobe_n(), .ctc_read_strobe_n(), .ctc_write_strobe_n(),
    .io_cycle_select_n, .dev_select_n, .system_port_select_n());
  task chk_io(input logic [8:0] e, g);
    comparisons++;
    if (g !== e) begin n_fail++; $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g); end
  endtask
  task chk_bit(input logic e, g);
    comparisons++;
    if (g !== e) begin n_fail++; $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g); end
  endtask
  task report_and_stop;
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Random video stalls stretch the processor wait beyond the I/O wait
  always @(posedge clk_sys) #1 {dma_active, video_read_active} = 2'($random(seed));
  // Result watcher: one note per read or write cycle, taken when the I/O wait ends
  // Sampled on the falling edge so outputs launched at the rising edge have settled
  always @(negedge clk_sys) begin
    if (!io_stretch_wait_n) len++;
    if (io_stretch_wait_n && !prev_w && q.size() > 0) begin
      chk_io(q.pop_front(), {io_direction_line, dev_select_n});
      chk_bit(1, len >= 3 * TD && len <= 4 * TD + 1);
      len = 0;
    end
    prev_w = io_stretch_wait_n;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1;
    for (i = 0; i < 24; i++) begin
      a = 8'($random(seed));
      w = 1'($random(seed));
      if (i < 8) a = {1'b0, 3'(i), 4'h0}; // Every select line once
      q.push_back({~w, a[7] ? 8'hFF : ~(8'h01 << a[6:4])});
      u_cig_cpu.cycle({1'b0, w}, a);
      u_cig_cpu.cycle(2'd2, a);
    end
    @(posedge clk_sys) #1 pushbutton = 1;
    @(posedge clk_sys) #1 hsync = 1;
    @(posedge clk_sys) #1 hsync = 0;
    repeat (12) @(posedge clk_sys);
    chk_bit(0, sys_reset_n | pb_irq_n);
    #1 hsync = 1;
    repeat (3) @(posedge clk_sys);
    chk_bit(1, sys_reset_n);
    #1 power_on_n = 0;
    @(posedge clk_sys) chk_bit(0, sys_reset_n);
    #1 power_on_n = 1;
    repeat (4) @(posedge clk_sys);
    chk_bit(1, sys_reset_n);
    report_and_stop;
  end
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
endmodule
